// [core/crod_cfg.svh]
// Constants of the clock and reset option decoder
`ifndef CROD_CFG_SVH
`define CROD_CFG_SVH
`define CROD_PKG_BIT      7
`define CROD_RSTLEN_BIT   6
`define CROD_SRC_HI       5
`define CROD_SRC_LO       4
`define CROD_RANGE_HI     3
`define CROD_RANGE_LO     1
`define CROD_PLL_BIT      0
`define CROD_CFG_ERASED   8'hFF
`define CROD_LONG_CYCLES  13'h1000
`define CROD_SHORT_CYCLES 13'h0100
`define CROD_RANGE_MEDIUM 3'h1
`define CROD_PADS         8
`endif

// [core/crod_pkg.sv]
// Types of the clock and reset option decoder
package crod_pkg;
    typedef enum logic [1:0] {
        CROD_SRC_RESONATOR = 2'h0,
        CROD_SRC_RESERVED  = 2'h1,
        CROD_SRC_RC        = 2'h2,
        CROD_SRC_EXTERNAL  = 2'h3
    } crod_src_t;

    typedef struct packed {
        logic        large_package;
        logic        long_reset;
        crod_src_t   clock_source_type;
        logic [2:0]  resonator_range_select;
        logic        doubler_enable;
    } crod_sel_t;
endpackage : crod_pkg

// [core/crod_phase_counter.sv]
// Reset and halt-exit phase counter
`timescale 1ns/1ps
`default_nettype none
`include "crod_cfg.svh"
module crod_phase_counter (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_b,
    input  wire logic        i_ce,
    input  wire logic        i_start,
    input  wire logic [12:0] i_length,
    output logic             o_busy
);
    logic [12:0] count_r;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            count_r <= 13'h0000;
        end else if (i_ce) begin
            if (i_start) begin
                count_r <= i_length;
            end else if (count_r != 13'h0000) begin
                count_r <= count_r - 13'h0001;
            end
        end
    end

    assign o_busy = (count_r != 13'h0000);
endmodule : crod_phase_counter
`default_nettype wire

// [core/crod_decoder.sv]
// Option byte one decoder with reset phase control
//
// Behaviour
// - Bit 6 picks 4096 or 256 cycles
// - Bits 5:4 select main clock source
// - Bits 3:1 set resonator current range
// - External clock forces medium 2-4 MHz range
// - Bit 0 low enables times-two doubler
// - Bit 7 high means 64-lead package
// - Unbonded pads reset as pulled-up inputs
// - Option byte has no memory map address
`timescale 1ns/1ps
`default_nettype none
`include "crod_cfg.svh"
module crod_decoder
    import crod_pkg::*;
(
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst_b,
    input  wire logic                 i_ce,
    input  wire logic [7:0]           i_option_byte,
    input  wire logic                 i_halt_exit,
    output crod_pkg::crod_sel_t       o_sel,
    output logic [12:0]               o_phase_length,
    output logic                      o_phase_active,
    output logic [`CROD_PADS-1:0]     o_upper_pad_pullup,
    output logic [`CROD_PADS-1:0]     o_upper_pad_input
);
    import crod_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Capture while reset is held; no bus reaches this byte
    logic [7:0]  opt_r;
    logic        in_reset_r;
    logic        start_nxt;
    crod_sel_t   sel_nxt;
    logic [12:0] len_nxt;

    always_ff @(posedge i_mclk) begin
        if (i_ce && !i_rst_b) begin
            opt_r <= i_option_byte;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            in_reset_r <= 1'b1;
        end else if (i_ce) begin
            in_reset_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field decode
    always_comb begin
        sel_nxt.large_package     = opt_r[`CROD_PKG_BIT];
        sel_nxt.long_reset        = ~opt_r[`CROD_RSTLEN_BIT];
        sel_nxt.clock_source_type =
            crod_src_t'(opt_r[`CROD_SRC_HI:`CROD_SRC_LO]);
        if (sel_nxt.clock_source_type == CROD_SRC_EXTERNAL) begin
            sel_nxt.resonator_range_select = `CROD_RANGE_MEDIUM;
        end else begin
            sel_nxt.resonator_range_select =
                opt_r[`CROD_RANGE_HI:`CROD_RANGE_LO];
        end
        // Enable follows the bit as written; bad combinations are the tool's
        sel_nxt.doubler_enable = ~opt_r[`CROD_PLL_BIT];
        len_nxt = sel_nxt.long_reset ? `CROD_LONG_CYCLES
                                     : `CROD_SHORT_CYCLES;
    end

    ////////////////////////////////////////////////////////////////////////
    // Held outputs, stable until the next reset
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_sel          <= '0;
            o_phase_length <= `CROD_LONG_CYCLES;
        end else if (i_ce && in_reset_r) begin
            o_sel          <= sel_nxt;
            o_phase_length <= len_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Phase counter, started on reset release and on halt exit
    logic busy;

    assign start_nxt = in_reset_r | i_halt_exit;

    crod_phase_counter u_phase (
        .i_mclk   (i_mclk),
        .i_rst_b  (i_rst_b),
        .i_ce     (i_ce),
        .i_start  (start_nxt),
        .i_length (len_nxt),
        .o_busy   (busy)
    );

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_phase_active <= 1'b1;
        end else if (i_ce) begin
            o_phase_active <= busy | start_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Check helper: enabled edges since the last start of the phase
    // Kept apart from the phase counter so the checks do not reuse
    // the very logic they are meant to judge
    logic [12:0] run_len_r;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            run_len_r <= 13'h0000;
        end else if (i_ce) begin
            if (start_nxt) begin
                run_len_r <= 13'h0000;
            end else if (o_phase_active) begin
                run_len_r <= run_len_r + 13'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pads of the upper port bond only in the large package
    genvar g;
    generate
        for (g = 0; g < `CROD_PADS; g = g + 1) begin : g_pad
            always_ff @(posedge i_mclk) begin
                if (!i_rst_b) begin
                    o_upper_pad_pullup[g] <= 1'b1;
                    o_upper_pad_input[g]  <= 1'b1;
                end else if (i_ce) begin
                    o_upper_pad_pullup[g] <= ~o_sel.large_package;
                    o_upper_pad_input[g]  <= ~o_sel.large_package;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // All on the core clock and quiet while reset is held low
    sequence s_started;
        start_nxt && i_ce;
    endsequence

    // An enabled edge of a running phase that does not restart the count
    sequence s_phase_step;
        i_ce && !start_nxt && o_phase_active;
    endsequence

    sequence s_halt_pulse;
        i_ce && i_halt_exit;
    endsequence

    // Decode of the sampled byte, one edge after release
    a_short_phase_len: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && in_reset_r && opt_r[`CROD_RSTLEN_BIT]) |=>
        o_phase_length == 13'h0100) else $error("short phase length wrong");
    a_long_phase_len: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && in_reset_r && !opt_r[`CROD_RSTLEN_BIT]) |=>
        o_phase_length == 13'h1000) else $error("long phase length wrong");
    a_long_reset_bit: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && in_reset_r) |=> o_sel.long_reset == ~$past(opt_r[6]))
        else $error("reset length decode wrong");
    a_ext_range_forced: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_sel.clock_source_type == CROD_SRC_EXTERNAL |->
        o_sel.resonator_range_select == 3'h1) else $error("range not forced");
    a_range_passthru: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && in_reset_r && opt_r[5:4] != 2'h3) |=>
        o_sel.resonator_range_select == $past(opt_r[3:1])) else $error("range decode wrong");
    a_sel_held_stable: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        !in_reset_r |=> $stable(o_sel))
        else $error("selection changed");
    a_doubler_bit: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && in_reset_r) |=> o_sel.doubler_enable == ~$past(opt_r[0]))
        else $error("doubler decode wrong");
    a_package_bit: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && in_reset_r) |=> o_sel.large_package == $past(opt_r[7]))
        else $error("package decode wrong");
    a_source_field: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && in_reset_r) |=> o_sel.clock_source_type == $past(opt_r[5:4]))
        else $error("source decode wrong");

    // Phase timing from reset release and from halt exit
    a_phase_runs: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        s_started |=> o_phase_active [*8])
        else $error("phase ended early");
    a_halt_restart: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        s_halt_pulse |=> (o_phase_active && run_len_r == 13'h0000))
        else $error("halt exit did not restart phase");
    a_phase_not_early: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (s_phase_step ##0 (run_len_r < o_phase_length)) |=> o_phase_active)
        else $error("phase ended before its length");
    a_phase_exact_end: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (s_phase_step ##0 (run_len_r == o_phase_length)) |=> !o_phase_active)
        else $error("phase overran its length");
    a_phase_idle: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && !start_nxt && !o_phase_active) |=> !o_phase_active)
        else $error("phase rose without a start");

    // Pads and clock-enable freeze
    a_pads_follow: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && !o_sel.large_package) |=> o_upper_pad_pullup == 8'hFF)
        else $error("unbonded pads not pulled up");
    a_pads_input: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && !o_sel.large_package) |=> o_upper_pad_input == 8'hFF)
        else $error("unbonded pads not inputs");
    a_pads_bonded: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && o_sel.large_package) |=>
        (o_upper_pad_pullup == 8'h00 && o_upper_pad_input == 8'h00))
        else $error("bonded pads left pulled up");
    a_frozen_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        !i_ce |=> ($stable(o_sel) && $stable(o_phase_active) && $stable(o_upper_pad_pullup)))
        else $error("state moved while frozen");
endmodule : crod_decoder
`default_nettype wire

// [dv/crod_prog_tool.sv]
// Programming tool model that owns the option byte
`timescale 1ns/1ps
`default_nettype none
`include "crod_cfg.svh"
module crod_prog_tool (
    output logic [7:0] o_byte
);
    initial o_byte = `CROD_CFG_ERASED;
    ////////////////////////////////////////////////////////////////
    // Only this tool writes the byte; it never loads illegal combos
    task write_byte(input logic [7:0] b);
        logic [7:0] v;
        v = b;
        if (v[5:4] == 2'h0) v[6] = 1'b0;
        if (v[5:4] == 2'h2 || (v[5:4] != 2'h3 && v[3:1] != 3'h1)) v[0] = 1'b1;
        o_byte = v;
    endtask : write_byte
endmodule : crod_prog_tool
`default_nettype wire

// [dv/crod_decoder_tb_top.sv]
// Self-checking bench for the option byte decoder
`timescale 1ns/1ps
`default_nettype none
module crod_decoder_tb_top;
    import crod_pkg::*;
    typedef struct packed { logic [1:0] kind; logic [15:0] val; } crod_note_t;
    logic i_mclk = 1'b0, i_rst_b = 1'b0, i_ce = 1'b1, i_halt_exit = 1'b0;
    wire logic [7:0] opt;
    crod_sel_t   sel;
    logic [12:0] plen;
    logic        act;
    logic [7:0]  pu, pin;
    int          mismatches = 0, n_tests = 0;
    crod_note_t  notes[$];
    event        chk_ev;
    crod_prog_tool i_crod_prog_tool (.o_byte(opt));
    crod_decoder i_crod_decoder (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ce(i_ce),
        .i_option_byte(opt), .i_halt_exit(i_halt_exit), .o_sel(sel), .o_phase_length(plen),
        .o_phase_active(act), .o_upper_pad_pullup(pu), .o_upper_pad_input(pin));
    initial forever #2.5 i_mclk = ~i_mclk;
    ////////////////////////////////////////////////////////////////
    function automatic logic [15:0] got(input logic [1:0] k);
        case (k)
            2'h0: got = {8'h00, sel};
            2'h1: got = {3'h0, plen};
            2'h2: got = {pu, pin};
            default: got = {15'h0000, act};
        endcase
    endfunction : got
    task note(input logic [1:0] k, input logic [15:0] v);
        notes.push_back('{k, v});
        -> chk_ev;
    endtask : note
    // Drains all notes so same-step triggers are never lost
    initial forever begin
        crod_note_t n;
        @(chk_ev);
        while (notes.size() > 0) begin
            n = notes.pop_front();
            n_tests++;
            if (got(n.kind) !== n.val) begin
                mismatches++;
                $display("unexpected at %0t: got %h exp %h", $time, got(n.kind), n.val);
            end
        end
    end
    task step(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : step
    task conclude;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////
    task run_cfg(input logic [7:0] b);
        logic [7:0]  e;
        logic [12:0] len;
        logic [15:0] xs;
        i_rst_b = 1'b0;
        i_crod_prog_tool.write_byte(b);
        e = opt;
        step(3);
        i_rst_b = 1'b1;
        step(1);
        len = e[6] ? 13'h0100 : 13'h1000;
        xs = {8'h00, e[7], ~e[6], e[5:4], (e[5:4] == 2'h3) ? 3'h1 : e[3:1], ~e[0]};
        i_crod_prog_tool.write_byte(~e);
        note(2'h0, xs);
        note(2'h1, {3'h0, len});
        step(1);
        note(2'h2, {{8{~e[7]}}, {8{~e[7]}}});
        step(len - 1);
        note(2'h3, 16'h0001);
        step(1);
        note(2'h3, 16'h0000);
        note(2'h0, xs);
        i_halt_exit = 1'b1;
        step(1);
        i_halt_exit = 1'b0;
        // Frozen edges must stretch the halt-exit phase by four cycles
        i_ce = 1'b0;
        step(4);
        note(2'h3, 16'h0001);
        i_ce = 1'b1;
        step(len);
        note(2'h3, 16'h0001);
        step(1);
        note(2'h3, 16'h0000);
    endtask : run_cfg
    // Erased byte, each source code, forced range, both packages
    logic [7:0] cfgs [6] = '{8'hFF, 8'h02, 8'h27, 8'h5E, 8'hB6, 8'h87};
    initial begin
        void'($urandom(32'h396fab7c));
        // Reset low from time zero; run_cfg adds three edges, five in all
        step(2);
        foreach (cfgs[i]) run_cfg(cfgs[i]);
        repeat (2) run_cfg(8'($urandom));
        step(2);
        conclude();
    end
    initial begin
        // Tests need about 51000 cycles; 60000 leaves a margin
        #(60000 * 5);
        mismatches++;
        conclude();
    end
endmodule : crod_decoder_tb_top
`default_nettype wire
